// [design/dual_pll_ratio_divider_control.sv]
// Register file and effective settings of the two frequency-synthesis loops
// Contract
// (R1) Receiver off: all settings from software
// (R2) Fraction is 22 bits over three registers
// (R3) Integer in bits 7:4, resets to 0111
// (R4) Fraction segments reset to documented values
// (R5) Loop A first two registers read ID
// (R6) No ID readback during continuous readback
// (R7) Loop A third register reads revision
// (R8) Ratio equals integer plus fraction over 2^22
// (R9) Software keeps integer in 5..13
// (R10) Pre-scale bit halves the oscillator input
// (R11) User divider 2,4,8,12, doubled by post-scale
// (R12) Receiver mode: post-scale picks 256fs/128fs
// (R13) Receiver drives loop A; B divider unused
// (R14) Software copies B pre-scale into A
// (R15) Software sets loop B for receiver reference
// (R16) Receiver steers loop A to track stream
`timescale 1ns/1ns
`include "loop_ctrl_defs.svh"
module dual_pll_ratio_divider_control (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      receiver_enable_i,
  input  wire logic                      continuous_readback_i,
  input  wire logic [21:0]               rx_fraction_i,
  input  wire logic [3:0]                rx_integer_i,
  output logic      [21:0]               loop_a_fraction_o,
  output logic      [3:0]                loop_a_integer_o,
  output logic                           loop_a_input_halve_o,
  output logic      [4:0]                loop_a_out_factor_o,
  output logic      [21:0]               loop_b_fraction_o,
  output logic      [3:0]                loop_b_integer_o,
  output logic                           loop_b_input_halve_o,
  output logic      [4:0]                loop_b_out_factor_o,
  output logic      [25:0]               loop_a_ratio_o,
  output logic      [25:0]               loop_b_ratio_o,
  output logic                           receiver_mode_o
);
  import loop_ctrl_pkg::*;

  // Eight stored configuration words, loop A at 0..3, loop B at 4..7
  reg9_t regs_q [0:7];
  bus_state_t bus_q;

  // Bus decode: word index from byte address, bit 5 selects the mode register
  wire logic [2:0] index;
  wire logic       mode_sel;
  wire logic       unmapped;
  wire logic       request;
  wire logic       wr_fire;
  wire logic       lanes_lo;
  wire logic       lanes_hi;
  assign index    = wb_adr_i[4:2];
  assign mode_sel = wb_adr_i[`WB_ADDR_MODE_BIT];
  assign unmapped = wb_adr_i[7:6] != 2'b00 || (mode_sel && index != `OFS_MODE);
  assign request  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_fire  = request && wb_we_i && !mode_sel && !unmapped;
  assign lanes_lo = wb_sel_i[0];
  assign lanes_hi = wb_sel_i[1];

  // Receiver enable means receiver mode, otherwise user mode
  wire logic rx_mode;
  assign rx_mode = receiver_enable_i; // see (R1)

  // Register storage with byte-lane writes; bit 8 rides lane 1
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_reg
      wire logic hit;
      wire reg9_t rst_val;
      assign hit = wr_fire && index == 3'(g);
      assign rst_val = (g % 4 == 0) ? `RST_FRAC_LOW :              // see (R4)
                       (g % 4 == 1) ? `RST_FRAC_MID :              // see (R4)
                       (g % 4 == 2) ? {1'b0, `RST_INTEGER, `RST_FRAC_TOP} : // see (R3)
                       `RST_DIVIDERS;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          regs_q[g] <= rst_val;
        end else if (hit) begin
          if (lanes_lo) begin
            regs_q[g][7:0] <= wb_dat_i[7:0];
          end
          if (lanes_hi) begin
            regs_q[g][8] <= wb_dat_i[8];
          end
        end
      end
    end
  endgenerate

  // Field extraction: fraction split 8:0, 17:9, 21:18
  wire fraction_t a_frac_sw;
  wire fraction_t b_frac_sw;
  wire integer_t  a_int_sw;
  wire integer_t  b_int_sw;
  assign a_frac_sw = {regs_q[2][3:0], regs_q[1], regs_q[0]}; // see (R2)
  assign b_frac_sw = {regs_q[6][3:0], regs_q[5], regs_q[4]}; // see (R2)
  assign a_int_sw  = regs_q[2][7:`POS_INTEGER];              // see (R3)
  assign b_int_sw  = regs_q[6][7:`POS_INTEGER];              // see (R3)

  // Loop A multipliers come from the receiver while it is enabled
  wire fraction_t a_frac_eff;
  wire integer_t  a_int_eff;
  assign a_frac_eff = rx_mode ? rx_fraction_i : a_frac_sw; // see (R13) (R16)
  assign a_int_eff  = rx_mode ? rx_integer_i  : a_int_sw;  // see (R13) (R16)

  // Loop configuration carriers into the divider decoders
  loop_cfg_if cfg_a ();
  loop_cfg_if cfg_b ();
  assign cfg_a.fraction       = a_frac_eff;
  assign cfg_a.integer_part   = a_int_eff;
  assign cfg_a.input_halve    = regs_q[3][`BIT_INPUT_HALVE];
  assign cfg_a.out_div_code   = regs_q[3][`POS_OUT_CODE+1:`POS_OUT_CODE];
  assign cfg_a.out_double_div = regs_q[3][`BIT_OUT_DOUBLE];
  assign cfg_a.receiver_mode  = rx_mode;                     // see (R13)
  assign cfg_a.rx_fs128       = regs_q[3][`BIT_OUT_DOUBLE];  // see (R12)
  assign cfg_b.fraction       = b_frac_sw;
  assign cfg_b.integer_part   = b_int_sw;
  assign cfg_b.input_halve    = regs_q[7][`BIT_INPUT_HALVE];
  assign cfg_b.out_div_code   = regs_q[7][`POS_OUT_CODE+1:`POS_OUT_CODE];
  assign cfg_b.out_double_div = regs_q[7][`BIT_OUT_DOUBLE];
  assign cfg_b.receiver_mode  = 1'b0;
  assign cfg_b.rx_fs128       = 1'b0;

  wire logic [4:0] a_factor;
  wire logic [4:0] b_factor;
  loop_out_divider u_div_a (
    .cfg      (cfg_a),
    .factor_o (a_factor)
  );
  loop_out_divider u_div_b (
    .cfg      (cfg_b),
    .factor_o (b_factor)
  );

  // Ratio in 4.22 fixed point: concatenation is the additive sum
  wire logic [25:0] a_ratio;
  wire logic [25:0] b_ratio;
  assign a_ratio = {a_int_eff, a_frac_eff}; // see (R8)
  assign b_ratio = {b_int_sw, b_frac_sw};   // see (R8)

  // Effective settings registered onto the outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_a_fraction_o    <= {`RST_FRAC_TOP, `RST_FRAC_MID, `RST_FRAC_LOW};
      loop_a_integer_o     <= `RST_INTEGER;
      loop_a_input_halve_o <= 1'b0;
      loop_a_out_factor_o  <= 5'h08;
      loop_b_fraction_o    <= {`RST_FRAC_TOP, `RST_FRAC_MID, `RST_FRAC_LOW};
      loop_b_integer_o     <= `RST_INTEGER;
      loop_b_input_halve_o <= 1'b0;
      loop_b_out_factor_o  <= 5'h08;
      loop_a_ratio_o       <= {`RST_INTEGER, `RST_FRAC_TOP, `RST_FRAC_MID, `RST_FRAC_LOW};
      loop_b_ratio_o       <= {`RST_INTEGER, `RST_FRAC_TOP, `RST_FRAC_MID, `RST_FRAC_LOW};
      receiver_mode_o      <= 1'b0;
    end else begin
      loop_a_fraction_o    <= a_frac_eff;
      loop_a_integer_o     <= a_int_eff;
      loop_a_input_halve_o <= cfg_a.input_halve; // see (R10) (R14)
      loop_a_out_factor_o  <= a_factor;          // see (R11) (R12)
      loop_b_fraction_o    <= b_frac_sw;         // see (R15)
      loop_b_integer_o     <= b_int_sw;
      loop_b_input_halve_o <= cfg_b.input_halve; // see (R10)
      loop_b_out_factor_o  <= b_factor;          // see (R11)
      loop_a_ratio_o       <= a_ratio;
      loop_b_ratio_o       <= b_ratio;
      receiver_mode_o      <= rx_mode;
    end
  end

  // Readback: loop A's first two words return identity unless continuous readback; the third always returns revision
  wire logic   id_ok;
  wire reg9_t  rd_word;
  wire logic [31:0] rd_data;
  assign id_ok   = !continuous_readback_i; // see (R6)
  assign rd_word = (id_ok && index == `OFS_A_FRAC_LOW)      ? {1'b0, `DEVICE_ID_1} :     // see (R5)
                   (id_ok && index == `OFS_A_FRAC_MID)      ? {1'b0, `DEVICE_ID_2} :     // see (R5)
                   (index == `OFS_A_FRAC_HIGH_INT)          ? {1'b0, `DEVICE_REVISION} : // see (R7)
                   regs_q[index];
  assign rd_data = unmapped ? 32'h0000_0000 :
                   mode_sel ? {31'h0000_0000, rx_mode} : {23'h00_0000, rd_word};

  // One-cycle ack; ack falls in the cycle after, so back-to-back takes two cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q    <= BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      unique case (bus_q)
        BUS_IDLE: begin
          wb_ack_o <= request;
          wb_dat_o <= request ? rd_data : 32'h0000_0000;
          bus_q    <= request ? BUS_ACK : BUS_IDLE;
        end
        BUS_ACK: begin
          wb_ack_o <= 1'b0;
          wb_dat_o <= 32'h0000_0000;
          bus_q    <= BUS_IDLE;
        end
      endcase
    end
  end
endmodule : dual_pll_ratio_divider_control

// [design/loop_out_divider.sv]
// Output divider factor decode for one loop
`timescale 1ns/1ns
module loop_out_divider (
  loop_cfg_if.dst        cfg,
  output wire logic [4:0] factor_o
);
  import loop_ctrl_pkg::*;
  // Base factor from the code, doubled by post-scale
  wire logic [4:0] base_factor;
  assign base_factor = (cfg.out_div_code == 2'b00) ? 5'h02 :
                       (cfg.out_div_code == 2'b01) ? 5'h04 :
                       (cfg.out_div_code == 2'b10) ? 5'h08 : 5'h0C; // see (R11)
  // Receiver mode: 256fs from f2 uses divide 8 reference, 128fs doubles it
  wire logic [4:0] rx_factor;
  assign rx_factor = cfg.rx_fs128 ? 5'h10 : 5'h08; // see (R12)
  assign factor_o = cfg.receiver_mode ? rx_factor :
                    (cfg.out_double_div ? {base_factor[3:0], 1'b0} : base_factor); // see (R11)
endmodule : loop_out_divider

// [pkg/loop_cfg_if.sv]
// Interface carrying one loop's configuration to its output divider decoder
`timescale 1ns/1ns
interface loop_cfg_if;
  import loop_ctrl_pkg::*;
  fraction_t fraction;
  integer_t  integer_part;
  logic      input_halve;
  logic [1:0] out_div_code;
  logic      out_double_div;
  logic      receiver_mode;
  logic      rx_fs128;
  modport src (output fraction, integer_part, input_halve, out_div_code, out_double_div,
               output receiver_mode, rx_fs128);
  modport dst (input fraction, integer_part, input_halve, out_div_code, out_double_div,
               input receiver_mode, rx_fs128);
endinterface : loop_cfg_if

// [pkg/loop_ctrl_defs.svh]
// Register offsets, field positions, reset values and constants for the loop control block
`ifndef LOOP_CTRL_DEFS_SVH
`define LOOP_CTRL_DEFS_SVH
`define OFS_A_FRAC_LOW      3'h0
`define OFS_A_FRAC_MID      3'h1
`define OFS_A_FRAC_HIGH_INT 3'h2
`define OFS_A_DIVIDERS      3'h3
`define OFS_B_FRAC_LOW      3'h4
`define OFS_B_FRAC_MID      3'h5
`define OFS_B_FRAC_HIGH_INT 3'h6
`define OFS_B_DIVIDERS      3'h7
`define OFS_MODE            3'h0
`define RST_FRAC_LOW        9'h121
`define RST_FRAC_MID        9'h17E
`define RST_FRAC_TOP        4'hD
`define RST_INTEGER         4'h7
`define RST_DIVIDERS        9'h010
`define BIT_INPUT_HALVE     0
`define BIT_OUT_DOUBLE      1
`define POS_OUT_CODE        3
`define POS_INTEGER         4
`define FRAC_BITS           22
`define DEVICE_ID_1         8'h5A
`define DEVICE_ID_2         8'hA5
`define DEVICE_REVISION     8'h03
`define WB_ADDR_MODE_BIT    5
`endif

// [pkg/loop_ctrl_pkg.sv]
// Types shared by the loop control block
package loop_ctrl_pkg;
  typedef logic [8:0]  reg9_t;
  typedef logic [21:0] fraction_t;
  typedef logic [3:0]  integer_t;
  typedef logic [4:0]  out_div_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;
endpackage : loop_ctrl_pkg

// [test/loop_ctrl_props.sv]
// Port assertions for the loop control block
`timescale 1ns/1ns
module loop_ctrl_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        receiver_enable_i,
  input wire logic        continuous_readback_i,
  input wire logic [21:0] rx_fraction_i,
  input wire logic [21:0] loop_a_fraction_o,
  input wire logic [3:0]  loop_a_integer_o,
  input wire logic [25:0] loop_a_ratio_o,
  input wire logic [4:0]  loop_b_out_factor_o,
  input wire logic        receiver_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken only while no answer is pending
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  // Mode needs two cycles because the mode flag is registered
  sequence s_rx2; receiver_enable_i [*2]; endsequence
  property p_ack; s_take |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
  property p_id; s_take ##0 (!wb_we_i && wb_adr_i == 8'h00 && !continuous_readback_i)
    |=> wb_dat_o == 32'h5A; endproperty
  a_id: assert property (p_id) else $error("identity byte wrong");
  property p_rev; s_take ##0 (!wb_we_i && wb_adr_i == 8'h08) |=> wb_dat_o == 32'h03; endproperty
  a_rev: assert property (p_rev) else $error("revision wrong");
  property p_ratio; loop_a_ratio_o == {loop_a_integer_o, loop_a_fraction_o}; endproperty
  a_ratio: assert property (p_ratio) else $error("ratio not integer plus fraction");
  property p_rx; s_rx2 |-> receiver_mode_o && loop_a_fraction_o == $past(rx_fraction_i);
  endproperty
  a_rx: assert property (p_rx) else $error("loop A not steered");
  property p_user; (!receiver_enable_i) [*2] |-> !receiver_mode_o; endproperty
  a_user: assert property (p_user) else $error("receiver mode while off");
  property p_factor; loop_b_out_factor_o inside {5'h02, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h18};
  endproperty
  a_factor: assert property (p_factor) else $error("illegal divide factor");
endmodule : loop_ctrl_props
bind dual_pll_ratio_divider_control loop_ctrl_props u_props (.*);

// [test/testbench.sv]
// Self-checking bench for the loop control block
`timescale 1ns/1ns
module testbench;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        receiver_enable_i, continuous_readback_i, receiver_mode_o;
  logic        loop_a_input_halve_o, loop_b_input_halve_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, rx_integer_i, loop_a_integer_o, loop_b_integer_o;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [21:0] rx_fraction_i, loop_a_fraction_o, loop_b_fraction_o;
  logic [4:0]  loop_a_out_factor_o, loop_b_out_factor_o;
  logic [25:0] loop_a_ratio_o, loop_b_ratio_o;
  int          failures = 0;
  int          checked = 0;
  dual_pll_ratio_divider_control dut (.*);
  // 100 ns clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] a, input logic [31:0] e);
    checked++;
    if (a !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : chk
  // One classic cycle, then an idle cycle so no strobe is raised twice per step
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    // Only the watchdog ends a wait for the answer
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rc
  task t_reset;
    chk(loop_b_fraction_o, 22'h36FD21);
    chk(loop_a_integer_o, 4'h7);
    rc(8'h10, 32'h121);
    rc(8'h18, 32'h07D);
    rc(8'h00, 32'h05A);
    rc(8'h04, 32'h0A5);
    rc(8'h08, 32'h003);
  endtask : t_reset
  task t_continuous_readback;
    continuous_readback_i <= 1'b1;
    rc(8'h00, 32'h121);
    rc(8'h04, 32'h17E);
    rc(8'h08, 32'h003);
    continuous_readback_i <= 1'b0;
  endtask : t_continuous_readback
  // Fraction split over three words, both loops
  task t_ratio;
    wr(8'h10, 32'h1BA);
    wr(8'h14, 32'h024);
    wr(8'h18, 32'h083);
    wr(8'h00, 32'h124);
    wr(8'h04, 32'h015);
    wr(8'h08, 32'h06B);
    chk(loop_b_ratio_o, {4'h8, 22'h0C49BA});
    chk(loop_a_ratio_o, {4'h6, 22'h2C2B24});
  endtask : t_ratio
  task t_divider;
    logic [4:0] e;
    for (int c = 0; c < 8; c++) begin
      e = (c[1:0] == 2'h3) ? 5'h0C : 5'h02 << c[1:0];
      e = e << c[2];
      wr(8'h0C, {27'h0, c[1:0], 1'b0, c[2], c[2]});
      wr(8'h1C, {27'h0, c[1:0], 1'b0, c[2], c[2]});
      chk(loop_a_out_factor_o, e);
      chk(loop_b_out_factor_o, e);
      chk(loop_b_input_halve_o, c[2]);
      chk(loop_a_input_halve_o, c[2]);
    end
  endtask : t_divider
  task t_receiver;
    receiver_enable_i <= 1'b1;
    rx_fraction_i <= 22'h155555;
    rx_integer_i <= 4'h9;
    wr(8'h0C, 32'h003);
    chk(loop_a_out_factor_o, 5'h10);
    chk(loop_a_input_halve_o, 1'b1);
    chk(loop_a_fraction_o, 22'h155555);
    chk(loop_a_integer_o, 4'h9);
    rc(8'h20, 32'h001);
    wr(8'h0C, 32'h019);
    chk(loop_a_out_factor_o, 5'h08);
    receiver_enable_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(loop_a_fraction_o, 22'h2C2B24);
    chk(loop_a_out_factor_o, 5'h0C);
  endtask : t_receiver
  task t_unmapped;
    rc(8'h40, 32'h000);
    wr(8'h20, 32'h1FF);
    rc(8'h20, 32'h000);
  endtask : t_unmapped
  task tally_and_finish;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    {receiver_enable_i, continuous_readback_i} = 2'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    rx_fraction_i = 22'h0;
    rx_integer_i = 4'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_continuous_readback();
    t_ratio();
    t_divider();
    t_receiver();
    t_unmapped();
    tally_and_finish();
  end
  // Watchdog, far beyond the 121 cycles needed
  initial begin
    repeat (2000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end
endmodule : testbench
